// >>> isolated_octal_switch_serial_control.sv
`timescale 1ns/1ps
`default_nettype none

// Committed frames wait here for the isolation link
module frame_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    // Storage and pointers kept as one state record
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } fifo_state_s;

    fifo_state_s s; // Registered state
    fifo_state_s next_s; // Next state
    logic push; // Write accepted
    logic pop; // Read accepted

    // Ready and valid straight from the count
    assign in_ready_o = (s.count != (AW+1)'(DEPTH));
    assign out_valid_o = (s.count != '0);
    assign out_data_o = s.mem[s.rd];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // Pointer and count update
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wr] = in_data_i;
            next_s.wr = s.wr + 1'b1;
        end
        if (pop) begin
            next_s.rd = s.rd + 1'b1;
        end
        // Simultaneous push and pop leave the count alone
        case ({push, pop})
            2'b10: next_s.count = s.count + 1'b1;
            2'b01: next_s.count = s.count - 1'b1;
            default: next_s.count = s.count;
        endcase
    end

    // State register
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

// Summary of operation
// - Sample serial input on clock rise while selected
// - Committed one turns channel on, zero off
// - Commit on select rise only at multiple of eight
// - Serial output driven only while selected
// - Deselected: ignore clock and data, output released
// - Serial output advances on clock fall
// - Input bits arrive most significant first
// - Shift register leaves most significant first
// - Plain shift register passes data down chain
// - Kill input asynchronously clears latches, outputs off
// - After kill, off until new valid frame
// - Fault flag ORs overtemperature and load undervoltage
// - Fault flag low when fault, else high
// - Four rejected link transfers force outputs off
// - Output stage waits for stable output supply
// - Hot channel alone runs low duty restart
module isolated_octal_switch_serial_control
    import iso_switch_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic output_kill_n_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic si_i,
    input wire logic link_reject_i,
    input wire logic supply_ok_i,
    input wire logic load_uv_i,
    input wire logic [NUM_CH-1:0] over_temp_i,
    output logic so_o,
    output logic so_oe_o,
    output logic [NUM_CH-1:0] switch_drive_o,
    output logic fault_flag_n_o,
    output logic fault_flag_oe_o
);
    sw_state_s s; // Registered state
    sw_state_s next_s; // Next state
    pin_in_s pins; // Raw pin bundle
    logic arst_n; // Combined clear: system reset or kill pin
    logic sclk_rise; // Serial clock edges, synchronised domain
    logic sclk_fall;
    logic cs_fall; // Select edges
    logic cs_rise;
    logic selected; // Select held low
    logic link_tick; // One cycle per link transfer slot
    logic fifo_in_ready; // Buffer can take a frame
    logic fifo_out_valid; // Buffer holds a frame
    logic fifo_out_ready; // Link takes a frame this cycle
    logic [FRAME_BITS-1:0] fifo_out_data;
    logic pwm_on; // Restart pulse window open
    logic any_fault; // Overtemperature or load undervoltage

    // Kill acts without the clock and clears every register
    assign arst_n = reset_n_i & output_kill_n_i;

    // Bundle the pins for the two-stage synchroniser
    assign pins = '{cs_n: cs_n_i, sclk: sclk_i, si: si_i,
        link_reject: link_reject_i, supply_ok: supply_ok_i,
        load_uv: load_uv_i, over_temp: over_temp_i};

    // Edge detection reads only the second stage and its delay
    assign sclk_rise = s.sync.sclk & ~s.prev.sclk;
    assign sclk_fall = ~s.sync.sclk & s.prev.sclk;
    assign cs_fall = ~s.sync.cs_n & s.prev.cs_n;
    assign cs_rise = s.sync.cs_n & ~s.prev.cs_n;
    assign selected = ~s.sync.cs_n & ~s.prev.cs_n;

    // Link slot divider and thermal restart window
    assign link_tick = (s.link_div == 8'(LINK_CYCLES - 1));
    assign pwm_on = (s.pwm < 12'(RESTART_ON_CYCLES));
    // The link only pulls frames once the output side is up
    assign fifo_out_ready = link_tick & (s.ost != ST_STARTUP);
    assign any_fault = (|s.sync.over_temp) | s.sync.load_uv;

    // Frames wait here so a busy link drops no commit unless the buffer is full and a frame is already pending
    frame_fifo #(
        .WIDTH(FRAME_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_frame_fifo (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n),
        .in_valid_i(s.pend),
        .in_ready_o(fifo_in_ready),
        .in_data_i(s.pend_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // Next-state logic for the whole block
    always_comb begin
        next_s = s;
        // Synchroniser: first stage feeds only the second
        next_s.meta = pins;
        next_s.sync = s.meta;
        next_s.prev = s.sync;

        // Serial side
        if (cs_fall) begin
            // New frame: restart the count, drive current top bit
            next_s.bit_cnt = '0;
            next_s.seen = 1'b0;
            next_s.so = s.shift[FRAME_BITS-1];
            next_s.so_oe = 1'b1;
        end else if (selected) begin
            // Master holds clock high at select edges, so no
            // spurious edge is counted here
            if (sclk_rise) begin
                // Top bit drops out, new bit enters at the bottom
                next_s.shift = {s.shift[FRAME_BITS-2:0],
                    s.sync.si};
                next_s.bit_cnt = s.bit_cnt + 1'b1;
                next_s.seen = 1'b1;
            end
            if (sclk_fall) begin
                next_s.so = s.shift[FRAME_BITS-1];
            end
        end
        // Deselected: clock and data are not looked at
        if (cs_rise) begin
            next_s.so_oe = 1'b0;
        end

        // Hand the pending frame to the buffer when it has room
        if (s.pend && fifo_in_ready) begin
            next_s.pend = 1'b0;
        end
        // A modulo-8 count of zero with at least one pulse commits;
        // frames held low across the whole frame are assumed
        if (cs_rise && s.seen && (s.bit_cnt == '0)) begin
            next_s.pend = 1'b1;
            // Only the final byte remains in the register
            next_s.pend_data = s.shift;
        end

        // Link slot divider
        if (link_tick) begin
            next_s.link_div = '0;
        end else begin
            next_s.link_div = s.link_div + 1'b1;
        end

        // Thermal restart pulse counter
        if (s.pwm == 12'(RESTART_CYCLES - 1)) begin
            next_s.pwm = '0;
        end else begin
            next_s.pwm = s.pwm + 1'b1;
        end

        // Output stage
        case (s.ost)
            ST_STARTUP: begin
                // Wait for a settled supply before enabling
                next_s.latch = LATCH_RESET;
                if (!s.sync.supply_ok) begin
                    next_s.startup = '0;
                end else if (s.startup ==
                        8'(STARTUP_CYCLES - 1)) begin
                    next_s.ost = ST_RUN;
                    next_s.rejects = '0;
                end else begin
                    next_s.startup = s.startup + 1'b1;
                end
            end
            ST_RUN, ST_FORCED_OFF: begin
                if (!s.sync.supply_ok) begin
                    // Lost supply: start over, channels off
                    next_s.ost = ST_STARTUP;
                    next_s.startup = '0;
                    next_s.latch = LATCH_RESET;
                end else if (fifo_out_valid && fifo_out_ready) begin
                    if (s.sync.link_reject) begin
                        // Rejected transfer is dropped
                        if (s.rejects != MAX_REJECTS) begin
                            next_s.rejects = s.rejects + 1'b1;
                        end
                        if (s.rejects == MAX_REJECTS - 3'h1) begin
                            next_s.ost = ST_FORCED_OFF;
                        end
                    end else begin
                        // Valid transfer reloads and re-enables
                        next_s.latch = fifo_out_data;
                        next_s.rejects = '0;
                        next_s.ost = ST_RUN;
                    end
                end
            end
            default: begin
                next_s.ost = ST_STARTUP;
            end
        endcase

        // Channel drive: a hot channel pulses, others unaffected.
        // The restart window is one shared counter, so every hot
        // channel pulses in step; a cool channel never sees it.
        for (int i = 0; i < NUM_CH; i++) begin
            next_s.drive[i] = (s.ost == ST_RUN) && s.latch[i]
                && (!s.sync.over_temp[i] || pwm_on);
        end

        // Open-drain fault flag pulls low on any fault
        next_s.fault_oe = any_fault;
        next_s.fault_n = ~any_fault;
    end

    // State register; kill or reset clear everything to off
    always_ff @(posedge clk_sys_i or negedge arst_n) begin
        if (!arst_n) begin
            // Select and clock idle high, so the synchroniser starts
            // at that level; clearing them low would fake edges once
            // the real pin levels ripple through after a clear
            s <= '{default: '0, ost: ST_STARTUP,
                fault_n: 1'b1, latch: LATCH_RESET,
                meta: '{cs_n: 1'b1, sclk: 1'b1, default: '0},
                sync: '{cs_n: 1'b1, sclk: 1'b1, default: '0},
                prev: '{cs_n: 1'b1, sclk: 1'b1, default: '0}};
        end else begin
            s <= next_s;
        end
    end

    // Outputs come straight from state flip-flops
    assign so_o = s.so;
    assign so_oe_o = s.so_oe;
    assign switch_drive_o = s.drive;
    assign fault_flag_n_o = s.fault_n;
    assign fault_flag_oe_o = s.fault_oe;
endmodule

`default_nettype wire

// >>> iso_switch_pkg.sv
package iso_switch_pkg;
    // Channel count and serial frame size
    localparam int NUM_CH = 8;
    localparam int FRAME_BITS = 8;
    localparam int FIFO_DEPTH = 16;
    // Consecutive rejected link transfers that force the outputs off
    localparam logic [2:0] MAX_REJECTS = 3'h4;
    // Reset value of the channel latches: all channels off
    localparam logic [7:0] LATCH_RESET = 8'h00;
    // Timing base
    localparam int CLK_PERIOD_NS = 40;
    // Interval between transfers across the isolation link
    localparam int LINK_PERIOD_NS = 320;
    localparam int LINK_CYCLES = LINK_PERIOD_NS / CLK_PERIOD_NS;
    // Output supply must stay good this long before the stage enables
    localparam int STARTUP_NS = 1000;
    localparam int STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // Thermal restart pulse train: period and on time
    localparam int RESTART_PERIOD_NS = 40000;
    localparam int RESTART_CYCLES = RESTART_PERIOD_NS / CLK_PERIOD_NS;
    localparam int RESTART_ON_NS = 4000;
    localparam int RESTART_ON_CYCLES = RESTART_ON_NS / CLK_PERIOD_NS;

    // Output stage states
    typedef enum logic [1:0] {
        ST_STARTUP,
        ST_RUN,
        ST_FORCED_OFF
    } out_state_e;

    // Pin inputs that cross into the system clock domain
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic si;
        logic link_reject;
        logic supply_ok;
        logic load_uv;
        logic [NUM_CH-1:0] over_temp;
    } pin_in_s;

    // Complete state of the serial control block
    typedef struct packed {
        pin_in_s meta;
        pin_in_s sync;
        pin_in_s prev;
        logic [FRAME_BITS-1:0] shift;
        logic [2:0] bit_cnt;
        logic seen;
        logic so;
        logic so_oe;
        logic pend;
        logic [FRAME_BITS-1:0] pend_data;
        logic [7:0] link_div;
        out_state_e ost;
        logic [7:0] startup;
        logic [2:0] rejects;
        logic [NUM_CH-1:0] latch;
        logic [11:0] pwm;
        logic [NUM_CH-1:0] drive;
        logic fault_n;
        logic fault_oe;
    } sw_state_s;
endpackage

// >>> switch_checker.sv
`timescale 1ns/1ps
`default_nettype none
module switch_checker
    import iso_switch_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic output_kill_n_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic si_i,
    input wire logic link_reject_i,
    input wire logic supply_ok_i,
    input wire logic load_uv_i,
    input wire logic [NUM_CH-1:0] over_temp_i,
    input wire logic so_o,
    input wire logic so_oe_o,
    input wire logic [NUM_CH-1:0] switch_drive_o,
    input wire logic fault_flag_n_o,
    input wire logic fault_flag_oe_o
);
    logic clr_n; // Either clear input wipes the block
    logic fault_src; // Any fault source at the pins
    logic [2:0] up_cnt; // Cycles since the last clear, saturating
    assign clr_n = reset_n_i & output_kill_n_i;
    assign fault_src = (|over_temp_i) | load_uv_i;
    // Skip the first edges, while synchronisers still refill
    always_ff @(posedge clk_sys_i or negedge clr_n) begin
        if (!clr_n) begin
            up_cnt <= 3'h0;
        end else if (up_cnt != 3'h7) begin
            up_cnt <= up_cnt + 3'h1;
        end
    end
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!clr_n);
    so_released_a: assert property (
        cs_n_i [*6] |-> !so_oe_o) else $error("serial out not released");
    so_driven_a: assert property (
        !cs_n_i [*6] |-> so_oe_o) else $error("serial out not driven");
    kill_clears_a: assert property (disable iff (!reset_n_i)
        !output_kill_n_i |-> switch_drive_o == '0)
        else $error("channels on during kill");
    kill_hold_a: assert property (
        $rose(output_kill_n_i) |-> (switch_drive_o == '0) [*8])
        else $error("channels on right after kill");
    fault_flag_a: assert property (
        $stable(fault_src) [*4] ##0 up_cnt == 3'h7
        |-> fault_flag_n_o == !fault_src) else $error("fault flag wrong");
    fault_oe_a: assert property (
        fault_flag_oe_o != fault_flag_n_o) else $error("fault pin enable");
    so_on_fall_a: assert property (
        so_oe_o && $past(so_oe_o) && $changed(so_o) |-> !$past(sclk_i, 2))
        else $error("serial out moved without clock fall");
    supply_loss_a: assert property (
        !supply_ok_i [*6] |-> switch_drive_o == '0)
        else $error("channels on without supply");
endmodule
`default_nettype wire

// >>> spi_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// Serial master: 4 cycles low, 4 high, so the serial clock period is 320 ns
module spi_master_model (
    input wire logic clk_i,
    input wire logic so_i,
    input wire logic so_oe_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic si_o
);
    logic [31:0] rx; // Bits read back from the serial output
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b1;
        si_o = 1'b0;
        rx = '0;
    end
    // Clock idles high, so both select edges see it high
    task automatic frame(input logic [31:0] d, input int nb);
        rx = '0;
        cs_n_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (int i = nb - 1; i >= 0; i--) begin
            sclk_o <= 1'b0;
            si_o <= d[i];
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            // Read late in the high phase; a released line has no pull,
            // so it shows the inverse and a missing drive mismatches
            rx = {rx[30:0], so_oe_i ? so_i : ~so_i};
        end
        cs_n_o <= 1'b1;
        si_o <= ~si_o; // Released data line must not look held
        repeat (8) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import iso_switch_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic kill_n = 1'b1, reject = 1'b0, sup_ok = 1'b1, uv = 1'b0;
    logic [NUM_CH-1:0] ot = '0, drive;
    logic cs_n, sclk, si, so, so_oe, flag_n, flag_oe;
    logic [31:0] d;
    logic [7:0] last = 8'h00, sh = 8'h00; // Expected latch and shifter
    int miscompares = 0;
    int n_checks = 0;
    int hot_on; // Cycles a hot channel was driven in one restart period
    int nb_tab[9] = '{8, 16, 7, 8, 9, 0, 24, 15, 8}; // Odd counts mixed in
    always #20 clk_sys_i = ~clk_sys_i;
    isolated_octal_switch_serial_control
        isolated_octal_switch_serial_control_inst (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .output_kill_n_i(kill_n), .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si),
        .link_reject_i(reject), .supply_ok_i(sup_ok), .load_uv_i(uv),
        .over_temp_i(ot), .so_o(so), .so_oe_o(so_oe),
        .switch_drive_o(drive), .fault_flag_n_o(flag_n),
        .fault_flag_oe_o(flag_oe));
    spi_master_model spi_master_model_inst (.clk_i(clk_sys_i), .so_i(so),
        .so_oe_i(so_oe), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si));
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Old shifter byte followed by the new bits, oldest first
    function automatic logic [63:0] stream(input logic [31:0] d, int nb);
        return ({56'h0, sh} << nb) | ({32'h0, d} & ((64'h1 << nb) - 64'h1));
    endfunction
    // Only whole bytes commit; anything else leaves the latch alone
    function automatic logic [7:0] exp_drive(input logic [31:0] d, int nb);
        return (nb > 0 && nb % 8 == 0) ? d[7:0] : last;
    endfunction
    task automatic xfer(input logic [31:0] d, int nb, logic [7:0] exp);
        logic [63:0] st;
        st = stream(d, nb);
        spi_master_model_inst.frame(d, nb);
        repeat (30) @(posedge clk_sys_i);
        check("so bits", 32'((st >> 8) & ((64'h1 << nb) - 64'h1)),
            spi_master_model_inst.rx);
        check("drive", {24'h0, exp}, {24'h0, drive});
        sh = st[7:0];
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Hang guard, far beyond the few thousand cycles the tests need
    initial begin
        #2000000;
        miscompares++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'he7ae));
        repeat (5) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        repeat (40) @(posedge clk_sys_i);
        check("so_oe idle", 32'h0, {31'h0, so_oe});
        foreach (nb_tab[i]) begin
            d = $urandom();
            last = exp_drive(d, nb_tab[i]);
            xfer(d, nb_tab[i], last);
        end
        // Three rejected transfers keep the old byte, the fourth blanks
        reject <= 1'b1;
        for (int k = 1; k <= 4; k++) begin
            xfer($urandom(), 8, (k < 4) ? last : 8'h00);
        end
        reject <= 1'b0;
        d = $urandom();
        xfer(d, 8, d[7:0]);
        kill_n <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        check("kill", 32'h0, {24'h0, drive});
        kill_n <= 1'b1;
        repeat (40) @(posedge clk_sys_i);
        check("after kill", 32'h0, {24'h0, drive});
        sh = 8'h00;
        d = $urandom();
        xfer(d, 8, d[7:0]);
        sup_ok <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        sup_ok <= 1'b1;
        repeat (40) @(posedge clk_sys_i);
        check("supply back", 32'h0, {24'h0, drive});
        d = $urandom();
        xfer(d, 16, d[7:0]);
        uv <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        check("flag uv", 32'h0, {31'h0, flag_n});
        check("flag oe", 32'h1, {31'h0, flag_oe});
        uv <= 1'b0;
        ot <= 8'h01 << ($urandom() % 8);
        repeat (6) @(posedge clk_sys_i);
        check("flag hot", 32'h0, {31'h0, flag_n});
        // One full restart period: the hot channel is on for the
        // restart on time only, the cool channels hold their latch
        hot_on = 0;
        repeat (RESTART_CYCLES) begin
            @(posedge clk_sys_i);
            if ((drive & ot) != '0) begin
                hot_on++;
            end
        end
        check("hot duty", ((d[7:0] & ot) != '0) ? RESTART_ON_CYCLES : 0,
            hot_on);
        check("cool chans", {24'h0, d[7:0] & ~ot},
            {24'h0, drive & ~ot});
        ot <= '0;
        repeat (6) @(posedge clk_sys_i);
        check("flag clear", 32'h1, {31'h0, flag_n});
        print_verdict();
    end
endmodule
bind isolated_octal_switch_serial_control
    switch_checker switch_checker_inst (.*);
`default_nettype wire
